// ---- hdl/buck_regs_pkg.sv ----
// Register map, field positions and reset values of the buck regulator setting bank.
// Assumes a 24-bit register port indexed by the printed register numbers.
package buck_regs_pkg;

  // ----------------------------------------
  // Port widths
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [5:0] IDX_ONE_A     = 6'h18;
  localparam logic [5:0] IDX_TWO_THREE = 6'h19;
  localparam logic [5:0] IDX_FOUR      = 6'h1A;
  localparam logic [5:0] IDX_FIVE      = 6'h1B;
  localparam logic [5:0] IDX_MODE      = 6'h1C;

  // ----------------------------------------
  // Writable bit masks, unused bits stay zero
  // ----------------------------------------
  localparam logic [23:0] MASK_ONE_A     = 24'h000FFF;
  localparam logic [23:0] MASK_TWO_THREE = 24'h7DFFFF;
  localparam logic [23:0] MASK_FOUR      = 24'hFFFFFF;
  localparam logic [23:0] MASK_FIVE      = 24'h007C1F;
  localparam logic [23:0] MASK_MODE      = 24'hFFC0FF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int W6 = 6;
  localparam int W5 = 5;
  localparam int W4 = 4;
  localparam int W2 = 2;
  localparam int ONE_A_NORM_LSB = 0;
  localparam int ONE_A_STBY_LSB = 6;
  localparam int TWO_NORM_LSB   = 0;
  localparam int TWO_STBY_LSB   = 6;
  localparam int THREE_NORM_LSB = 12;
  localparam int THREE_STBY_LSB = 18;
  localparam int FOUR_A_NORM_LSB = 0;
  localparam int FOUR_A_STBY_LSB = 5;
  localparam int FOUR_A_HI_LSB   = 10;
  localparam int FOUR_B_NORM_LSB = 12;
  localparam int FOUR_B_STBY_LSB = 17;
  localparam int FOUR_B_HI_LSB   = 22;
  localparam int FIVE_NORM_LSB   = 0;
  localparam int FIVE_STBY_LSB   = 10;
  localparam int ONE_A_MODE_LSB  = 0;
  localparam int ONE_A_HOLD_BIT  = 4;
  localparam int ONE_A_OFF_BIT   = 5;
  localparam int ONE_SLEW_LSB    = 6;
  localparam int TWO_MODE_LSB    = 14;
  localparam int TWO_HOLD_BIT    = 18;
  localparam int TWO_OFF_BIT     = 19;
  localparam int TWO_SLEW_LSB    = 20;
  localparam int PLL_EN_BIT      = 22;
  localparam int PLL_MULT_BIT    = 23;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam int          FOUR_UPPER_LSB = 16;
  localparam int          FOUR_UPPER_W   = 8;
  localparam logic [7:0]  FOUR_UPPER_RST = 8'h00;
  localparam logic [3:0]  AUTO_PULSE_SKIP = 4'h8;
  localparam logic [1:0]  SLEW_RST        = 2'h1;
  localparam logic [23:0] MODE_RST        = 24'h520048;
  localparam logic [23:0] MODE_OFF_MASK   = 24'h0C0030;
  localparam logic [23:0] MODE_MAIN_MASK  = 24'hF3C0CF;
  localparam logic        PIN_IDLE        = 1'b1;

endpackage : buck_regs_pkg

// ---- hdl/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for slow pins.
// Assumes pins held stable for several clocks; idles high under reset.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and filtered level
  input  wire logic pinIn,
  output logic      pinOut
);

  logic meta_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------
  // Chain; meta_r feeds s2_r only
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= buck_regs_pkg::PIN_IDLE;
      s2_r   <= buck_regs_pkg::PIN_IDLE;
      s3_r   <= buck_regs_pkg::PIN_IDLE;
      pinOut <= buck_regs_pkg::PIN_IDLE;
    end else begin
      meta_r <= pinIn;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      if (s2_r == s3_r) begin
        pinOut <= s3_r;
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- hdl/buck_setting_regs.sv ----
// Buck regulator voltage and operating mode register bank.
// Assumes a decoded register port from the serial control interface.
//
// Contract
// - Buck one-A normal code in bits 0-5, never reset.
// - Buck one-A standby code in bits 6-11; bits 12-23 read-only.
// - Buck two normal code in bits 0-5, untouched by resets.
// - Buck two standby code in bits 6-11.
// - Buck three normal code bits 12-16; bit 17 reads zero.
// - Buck three standby code bits 18-22; bit 23 reads zero.
// - Four-A normal 0-4, standby 5-9, high setting 10-11.
// - Four-B normal 12-16, standby 17-21, high setting 22-23.
// - Four register bits 16-23 main-reset; bits 0-15 never reset.
// - Five normal bits 0-4, standby 10-14; others read-only.
// - Five normal code bits 0-4 untouched by any reset.
// - One-A mode 0-3 default 8, hold/off bits off-reset, slew default 1.
// - Two mode 14-17, hold 18, off 19, slew 20-21; 8-13 zero.
// - Start-up reload sets mode fields from power-up select.
`timescale 1ns/100ps
`default_nettype none
module buck_setting_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Reset pins, asynchronous to clk
  input  wire logic        mainResetN,
  input  wire logic        offResetN,
  // Start-up sequencer
  input  wire logic        startupReload,
  input  wire logic [3:0]  powerupModeSelect,
  // Register port
  input  wire logic [5:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [23:0] regWrData,
  input  wire logic        regRead,
  output logic [23:0]      regRdData,
  output logic             regRdValid,
  // Regulator settings
  output logic [5:0]       buckOneANormal,
  output logic [5:0]       buckOneAStandby,
  output logic [5:0]       buckTwoNormal,
  output logic [5:0]       buckTwoStandby,
  output logic [4:0]       buckThreeNormal,
  output logic [4:0]       buckThreeStandby,
  output logic [4:0]       buckFourANormal,
  output logic [4:0]       buckFourAStandby,
  output logic [1:0]       buckFourAHighSetting,
  output logic [4:0]       buckFourBNormal,
  output logic [4:0]       buckFourBStandby,
  output logic [1:0]       buckFourBHighSetting,
  output logic [4:0]       buckFiveNormal,
  output logic [4:0]       buckFiveStandby,
  output logic [3:0]       buckOneAMode,
  output logic             buckOneAMemoryHold,
  output logic             buckOneAUserOff,
  output logic [1:0]       buckOneSlewSpeed,
  output logic [3:0]       buckTwoMode,
  output logic             buckTwoMemoryHold,
  output logic             buckTwoUserOff,
  output logic [1:0]       buckTwoSlewSpeed,
  output logic             switcherPllEnable,
  output logic             switcherPllMultiplier
);

  logic [23:0] oneA_r;
  logic [23:0] twoThree_r;
  logic [15:0] fourLow_r;
  logic [7:0]  fourUpper_r;
  logic [23:0] five_r;
  logic [23:0] mode_r;
  logic [23:0] mode_nxt;
  logic [23:0] rdMux;
  logic        mainSyncN;
  logic        offSyncN;
  logic        mainHit;
  logic        offHit;
  logic        wrOneA;
  logic        wrTwoThree;
  logic        wrFour;
  logic        wrFive;
  logic        wrMode;
  logic [23:0] four;
  logic [23:0] reloadMode;

  // ----------------------------------------
  // Reset pin synchronisers
  // ----------------------------------------
  pin_sync mainSync (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (mainResetN),
    .pinOut (mainSyncN)
  );
  pin_sync offSync (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (offResetN),
    .pinOut (offSyncN)
  );

  assign mainHit = ~mainSyncN;
  assign offHit  = ~offSyncN;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wrOneA     = regWrite && (regAddr == buck_regs_pkg::IDX_ONE_A);
  assign wrTwoThree = regWrite && (regAddr == buck_regs_pkg::IDX_TWO_THREE);
  assign wrFour     = regWrite && (regAddr == buck_regs_pkg::IDX_FOUR);
  assign wrFive     = regWrite && (regAddr == buck_regs_pkg::IDX_FIVE);
  assign wrMode     = regWrite && (regAddr == buck_regs_pkg::IDX_MODE);

  // ----------------------------------------
  // Voltage codes
  // ----------------------------------------
  // No reset on purpose: codes survive every reset so rails stay put
  always_ff @(posedge clk) begin
    if (wrOneA) begin
      oneA_r <= regWrData & buck_regs_pkg::MASK_ONE_A;
    end
    if (wrTwoThree) begin
      twoThree_r <= regWrData & buck_regs_pkg::MASK_TWO_THREE;
    end
    if (wrFour) begin
      fourLow_r <= regWrData[buck_regs_pkg::FOUR_A_NORM_LSB +: buck_regs_pkg::FOUR_UPPER_LSB];
    end
    if (wrFive) begin
      five_r <= regWrData & buck_regs_pkg::MASK_FIVE;
    end
  end

  // Upper byte of the four register splits four-B normal code at bit 16
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fourUpper_r <= buck_regs_pkg::FOUR_UPPER_RST;
    end else if (mainHit) begin
      fourUpper_r <= buck_regs_pkg::FOUR_UPPER_RST;
    end else if (wrFour) begin
      fourUpper_r <= regWrData[buck_regs_pkg::FOUR_UPPER_LSB +: buck_regs_pkg::FOUR_UPPER_W];
    end
  end

  assign four = {fourUpper_r, fourLow_r};

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  assign reloadMode = mode_r;

  always_comb begin
    mode_nxt = mode_r;
    if (wrMode) begin
      mode_nxt = regWrData & buck_regs_pkg::MASK_MODE;
    end
    if (startupReload) begin
      mode_nxt[buck_regs_pkg::ONE_A_MODE_LSB +: buck_regs_pkg::W4] = powerupModeSelect;
      mode_nxt[buck_regs_pkg::TWO_MODE_LSB +: buck_regs_pkg::W4]   = powerupModeSelect;
    end
    if (offHit) begin
      mode_nxt = mode_nxt & ~buck_regs_pkg::MODE_OFF_MASK;
    end
    if (mainHit) begin
      mode_nxt = (mode_nxt & buck_regs_pkg::MODE_OFF_MASK)
               | (buck_regs_pkg::MODE_RST & buck_regs_pkg::MODE_MAIN_MASK);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= buck_regs_pkg::MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped indices read zero
  assign rdMux = (regAddr == buck_regs_pkg::IDX_ONE_A)     ? oneA_r :
                 (regAddr == buck_regs_pkg::IDX_TWO_THREE) ? twoThree_r :
                 (regAddr == buck_regs_pkg::IDX_FOUR)      ? four :
                 (regAddr == buck_regs_pkg::IDX_FIVE)      ? five_r :
                 (regAddr == buck_regs_pkg::IDX_MODE)      ? reloadMode : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= rdMux;
      end
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  assign buckOneANormal       = oneA_r[buck_regs_pkg::ONE_A_NORM_LSB +: buck_regs_pkg::W6];
  assign buckOneAStandby      = oneA_r[buck_regs_pkg::ONE_A_STBY_LSB +: buck_regs_pkg::W6];
  assign buckTwoNormal        = twoThree_r[buck_regs_pkg::TWO_NORM_LSB +: buck_regs_pkg::W6];
  assign buckTwoStandby       = twoThree_r[buck_regs_pkg::TWO_STBY_LSB +: buck_regs_pkg::W6];
  assign buckThreeNormal      = twoThree_r[buck_regs_pkg::THREE_NORM_LSB +: buck_regs_pkg::W5];
  assign buckThreeStandby     = twoThree_r[buck_regs_pkg::THREE_STBY_LSB +: buck_regs_pkg::W5];
  assign buckFourANormal      = four[buck_regs_pkg::FOUR_A_NORM_LSB +: buck_regs_pkg::W5];
  assign buckFourAStandby     = four[buck_regs_pkg::FOUR_A_STBY_LSB +: buck_regs_pkg::W5];
  assign buckFourAHighSetting = four[buck_regs_pkg::FOUR_A_HI_LSB +: buck_regs_pkg::W2];
  assign buckFourBNormal      = four[buck_regs_pkg::FOUR_B_NORM_LSB +: buck_regs_pkg::W5];
  assign buckFourBStandby     = four[buck_regs_pkg::FOUR_B_STBY_LSB +: buck_regs_pkg::W5];
  assign buckFourBHighSetting = four[buck_regs_pkg::FOUR_B_HI_LSB +: buck_regs_pkg::W2];
  assign buckFiveNormal       = five_r[buck_regs_pkg::FIVE_NORM_LSB +: buck_regs_pkg::W5];
  assign buckFiveStandby      = five_r[buck_regs_pkg::FIVE_STBY_LSB +: buck_regs_pkg::W5];
  assign buckOneAMode         = mode_r[buck_regs_pkg::ONE_A_MODE_LSB +: buck_regs_pkg::W4];
  assign buckOneAMemoryHold   = mode_r[buck_regs_pkg::ONE_A_HOLD_BIT];
  assign buckOneAUserOff      = mode_r[buck_regs_pkg::ONE_A_OFF_BIT];
  assign buckOneSlewSpeed     = mode_r[buck_regs_pkg::ONE_SLEW_LSB +: buck_regs_pkg::W2];
  assign buckTwoMode          = mode_r[buck_regs_pkg::TWO_MODE_LSB +: buck_regs_pkg::W4];
  assign buckTwoMemoryHold    = mode_r[buck_regs_pkg::TWO_HOLD_BIT];
  assign buckTwoUserOff       = mode_r[buck_regs_pkg::TWO_OFF_BIT];
  assign buckTwoSlewSpeed     = mode_r[buck_regs_pkg::TWO_SLEW_LSB +: buck_regs_pkg::W2];
  assign switcherPllEnable    = mode_r[buck_regs_pkg::PLL_EN_BIT];
  assign switcherPllMultiplier = mode_r[buck_regs_pkg::PLL_MULT_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  oneA_hold_a: assert property (mainHit && !wrOneA |=> $stable(oneA_r)) else $error("one-A code moved");
  oneA_reserved_a: assert property (regRdValid && $past(regAddr) == buck_regs_pkg::IDX_ONE_A |->
    regRdData[23:12] == 12'h000) else $error("one-A reserved nonzero");
  twoThree_write_a: assert property (wrTwoThree |=> buckTwoNormal == $past(regWrData[5:0])
    && buckThreeStandby == $past(regWrData[22:18]) && twoThree_r[23] == 1'b0
    && twoThree_r[17] == 1'b0) else $error("two/three write wrong");
  four_upper_a: assert property (mainHit |=> fourUpper_r == buck_regs_pkg::FOUR_UPPER_RST)
    else $error("four upper not reset");
  four_write_a: assert property (wrFour && !mainHit |=> buckFourAHighSetting == $past(regWrData[11:10])
    && buckFourBHighSetting == $past(regWrData[23:22])) else $error("four write wrong");
  five_gap_a: assert property (wrFive |=> five_r[9:5] == 5'h00 && five_r[23:15] == 9'h000
    && buckFiveNormal == $past(regWrData[4:0])) else $error("five gap nonzero");
  mode_default_a: assert property (mainHit |=> buckOneAMode == buck_regs_pkg::AUTO_PULSE_SKIP
    && buckTwoMode == buck_regs_pkg::AUTO_PULSE_SKIP && buckOneSlewSpeed == buck_regs_pkg::SLEW_RST
    && mode_r[13:8] == 6'h00) else $error("mode default wrong");
  off_clear_a: assert property (offHit |=> !buckOneAUserOff && !buckTwoMemoryHold && !buckTwoUserOff
    && !buckOneAMemoryHold) else $error("off bits kept");
  pll_default_a: assert property (mainHit |=> switcherPllEnable && !switcherPllMultiplier)
    else $error("pll default wrong");
  reload_mode_a: assert property (startupReload && !mainHit |=> buckOneAMode == $past(powerupModeSelect)
    && buckTwoMode == $past(powerupModeSelect)) else $error("reload missed");

endmodule : buck_setting_regs
`default_nettype wire

// ---- hdl/unused_placeholder_none.sv ----
// Intentionally empty of logic: holds no module.
// Assumes nothing.

// ---- bench/reg_host.sv ----
// Host model that reaches the register bank through its register port.
// Assumes the bank takes a strobe at a rising edge and answers a read one cycle later.
`timescale 1ns/100ps
`default_nettype none
module reg_host (
  // Clock
  input  wire logic        clk,
  // Register port toward the device
  output logic [5:0]       regAddr,
  output logic             regWrite,
  output logic [23:0]      regWrData,
  output logic             regRead,
  input  wire logic [23:0] regRdData,
  input  wire logic        regRdValid
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    regAddr = 6'h00;
    regWrite = 1'b0;
    regWrData = 24'h000000;
    regRead = 1'b0;
  end

  // ----------------------------------------
  // Accesses, one strobe cycle each
  // ----------------------------------------
  task automatic writeReg(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask : writeReg

  // Bounded wait, so a missing answer shows as unknown data
  task automatic readReg(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    d = 'x;
    repeat (4) begin
      @(negedge clk);
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
    end
  endtask : readReg
endmodule : reg_host
`default_nettype wire

// ---- bench/tb_buck_setting_regs.sv ----
// Self-checking bench for the buck regulator setting register bank.
// Assumes the host model is compiled first; pins and reload driven here.
`timescale 1ns/100ps
`default_nettype none
module tb_buck_setting_regs;
  // ----------------------------------------
  // Signals and model
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        mainResetN = 1'b1;
  logic        offResetN = 1'b1;
  logic        startupReload = 1'b0;
  logic [3:0]  powerupModeSelect = 4'h0;
  logic [5:0]  regAddr;
  logic        regWrite, regRead, regRdValid;
  logic [23:0] regWrData, regRdData, rd;
  logic [31:0] d;
  logic [5:0]  buckOneANormal, buckOneAStandby, buckTwoNormal, buckTwoStandby;
  logic [4:0]  buckThreeNormal, buckThreeStandby, buckFourANormal, buckFourAStandby;
  logic [4:0]  buckFourBNormal, buckFourBStandby, buckFiveNormal, buckFiveStandby;
  logic [3:0]  buckOneAMode, buckTwoMode;
  logic [1:0]  buckFourAHighSetting, buckFourBHighSetting, buckOneSlewSpeed, buckTwoSlewSpeed;
  logic        buckOneAMemoryHold, buckOneAUserOff, buckTwoMemoryHold, buckTwoUserOff;
  logic        switcherPllEnable, switcherPllMultiplier;
  logic [23:0] view [5];
  logic [23:0] mdl [5];
  logic [23:0] mask [5] = '{24'h000FFF, 24'h7DFFFF, 24'hFFFFFF, 24'h007C1F, 24'hFFC0FF};
  int          failures = 0;
  int          n_checks = 0;

  always #12.5 clk = ~clk;

  // Output fields packed back into register layout
  assign view[0] = {12'h000, buckOneAStandby, buckOneANormal};
  assign view[1] = {1'b0, buckThreeStandby, 1'b0, buckThreeNormal, buckTwoStandby, buckTwoNormal};
  assign view[2] = {buckFourBHighSetting, buckFourBStandby, buckFourBNormal,
                    buckFourAHighSetting, buckFourAStandby, buckFourANormal};
  assign view[3] = {9'h000, buckFiveStandby, 5'h00, buckFiveNormal};
  assign view[4] = {switcherPllMultiplier, switcherPllEnable, buckTwoSlewSpeed, buckTwoUserOff,
                    buckTwoMemoryHold, buckTwoMode, 6'h00, buckOneSlewSpeed, buckOneAUserOff,
                    buckOneAMemoryHold, buckOneAMode};

  reg_host host (.clk, .regAddr, .regWrite, .regWrData, .regRead, .regRdData, .regRdValid);

  buck_setting_regs DUT (
    .clk, .reset, .mainResetN, .offResetN, .startupReload, .powerupModeSelect,
    .regAddr, .regWrite, .regWrData, .regRead, .regRdData, .regRdValid,
    .buckOneANormal, .buckOneAStandby, .buckTwoNormal, .buckTwoStandby, .buckThreeNormal,
    .buckThreeStandby, .buckFourANormal, .buckFourAStandby, .buckFourAHighSetting,
    .buckFourBNormal, .buckFourBStandby, .buckFourBHighSetting, .buckFiveNormal, .buckFiveStandby,
    .buckOneAMode, .buckOneAMemoryHold, .buckOneAUserOff, .buckOneSlewSpeed, .buckTwoMode,
    .buckTwoMemoryHold, .buckTwoUserOff, .buckTwoSlewSpeed, .switcherPllEnable,
    .switcherPllMultiplier
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Readback and output fields against the model
  task automatic verifyAll();
    for (int i = 0; i < 5; i++) begin
      host.readReg(6'h18 + 6'(i), rd);
      check($sformatf("readback %0d", i), mdl[i], rd);
      check($sformatf("fields %0d", i), mdl[i], view[i]);
    end
  endtask : verifyAll

  // Pin held low long enough to pass the synchroniser
  task automatic pulsePin(input bit isMain);
    @(posedge clk);
    if (isMain) mainResetN <= 1'b0;
    else offResetN <= 1'b0;
    repeat (8) @(posedge clk);
    mainResetN <= 1'b1;
    offResetN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : pulsePin

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9c5b5a8b));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    host.readReg(6'h1C, rd);
    check("mode after reset", 24'h520048, rd);
    check("mode fields after reset", 24'h520048, view[4]);
    host.readReg(6'h1A, rd);
    check("four upper after reset", 24'h000000, rd & 24'hFF0000);
    mdl[4] = 24'h520048;
    // Random words, back to back, all registers
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 5; i++) begin
        d = $urandom;
        host.writeReg(6'h18 + 6'(i), d[23:0]);
        mdl[i] = d[23:0] & mask[i];
      end
      verifyAll();
    end
    // Unmapped places: writes ignored, reads zero
    foreach (mask[i]) begin
      d = $urandom;
      host.writeReg(i[0] ? 6'h17 : 6'h1D + 6'(i), d[23:0]);
      host.readReg(i[0] ? 6'h00 : 6'h1D + 6'(i), rd);
      check("unmapped read", 24'h000000, rd);
    end
    verifyAll();
    // Off pin clears only hold and user-off bits
    host.writeReg(6'h1C, 24'hFFFFFF);
    pulsePin(1'b0);
    mdl[4] = 24'hF3C0CF;
    verifyAll();
    // Main pin: mode defaults, four upper byte, lower codes kept
    host.writeReg(6'h1C, 24'hFFFFFF);
    pulsePin(1'b1);
    mdl[4] = 24'h0C0030 | 24'h520048;
    mdl[2] = mdl[2] & 24'h00FFFF;
    verifyAll();
    // Start-up reload of both mode fields, every code
    for (int p = 0; p < 16; p++) begin
      @(posedge clk);
      powerupModeSelect <= 4'(p);
      startupReload <= 1'b1;
      @(posedge clk);
      startupReload <= 1'b0;
      mdl[4][3:0] = 4'(p);
      mdl[4][17:14] = 4'(p);
      host.readReg(6'h1C, rd);
      check("reload readback", mdl[4], rd);
      check("reload fields", mdl[4], view[4]);
    end
    // Mid-run reset: mode and four upper byte default, voltage codes kept
    d = $urandom;
    host.writeReg(6'h1A, d[23:0]);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    mdl[2] = d[23:0] & 24'h00FFFF;
    mdl[4] = 24'h520048;
    verifyAll();
    finish_test();
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule : tb_buck_setting_regs
`default_nettype wire
